// File: hbah_host_port.sv
`timescale 1ns/100ps
`default_nettype none

// How it works
// - in separate-strobe mode the ready line goes low as soon as the access becomes active.
// - in separate-strobe mode ready floats once the access goes inactive.
// - on a read the data bus is not driven before 3 pclk periods less 4 ns into the access.
// - in separate-strobe mode read data is valid one pclk period less 4 ns before ready rises.
// - read data stops being driven as soon as the read access goes inactive.
// - in direction-line mode acknowledge is driven high on access start and driven low to complete.
// - in direction-line mode acknowledge is driven high after the access ends, then floated.
// - in direction-line mode read data is valid one pclk period less 4 ns before acknowledge falls.

module hbah_host_port
  import hbah_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // mode: 1 = single data strobe with direction line
  input  wire logic       dir_mode,
  // host pins
  input  wire logic       sel_n,
  input  wire logic       write_or_data_strobe_n,
  input  wire logic       read_or_dir_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] data_i,
  output logic [7:0]      data_o,
  output logic            data_oe,
  output logic            ack_o,
  output logic            ack_oe,
  // internal register side
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);

  // ****************************************
  // access decode
  // ****************************************
  logic         wr_active;
  logic         rd_active;
  logic         active;
  logic         is_write;
  logic [7:0]   acc_len;
  logic         tmr_expired;
  logic [7:0]   tmr_elapsed;
  logic         tmr_start;
  logic         drive_ok;
  logic         rdata_ok;
  hbah_req_type req;

  assign wr_active = dir_mode ? (~sel_n & ~write_or_data_strobe_n & ~read_or_dir_n)
                              : (~sel_n & ~write_or_data_strobe_n);
  assign rd_active = dir_mode ? (~sel_n & ~write_or_data_strobe_n & read_or_dir_n)
                              : (~sel_n & ~read_or_dir_n);
  assign active    = wr_active | rd_active;
  assign is_write  = wr_active;

  function automatic logic [7:0] region_len(input logic [7:0] a);
    region_len = (a >= ACC_SLOW_BASE) ? ACC_SLOW_CYC : ACC_FAST_CYC;
  endfunction

  // access length never below what the read setup needs
  assign acc_len = (region_len(addr) > DRIVE_CNT + SETUP_CNT) ? region_len(addr)
                                                              : DRIVE_CNT + SETUP_CNT;

  // ****************************************
  // state machine
  // ****************************************
  hbah_state_type state_reg;
  hbah_state_type state_next;
  logic [1:0]     flt_reg;
  logic [1:0]     flt_next;
  logic [7:0]     rdata_reg;
  logic [7:0]     rdata_next;
  logic           rd_reg;
  logic           rd_next;
  hbah_drive_type ack_drv;

  assign tmr_start = (state_reg == HBAH_IDLE) & active;
  assign drive_ok  = rd_reg & (tmr_elapsed >= DRIVE_CNT) & (state_reg != HBAH_IDLE);
  assign rdata_ok  = tmr_elapsed >= DRIVE_CNT;

  always_comb begin
    state_next = state_reg;
    flt_next   = flt_reg;
    rd_next    = rd_reg;
    case (state_reg)
      HBAH_IDLE: begin
        flt_next = 2'b00;
        if (active) begin
          state_next = HBAH_WAIT;
          rd_next    = rd_active;
        end
      end
      HBAH_WAIT: begin
        if (!active) state_next = dir_mode ? HBAH_HOLD : HBAH_IDLE;
        else if (tmr_expired) state_next = HBAH_DONE;
      end
      HBAH_DONE: begin
        if (!active) state_next = dir_mode ? HBAH_HOLD : HBAH_IDLE;
      end
      HBAH_HOLD: begin
        state_next = HBAH_FLOAT;
      end
      HBAH_FLOAT: begin
        flt_next = flt_reg + 2'b01;
        if (flt_reg + 2'b01 >= FLOAT_CNT) state_next = HBAH_IDLE;
      end
      default: state_next = HBAH_IDLE;
    endcase
  end

  // read data captured once the drive window opens, stable before completion
  assign rdata_next = (state_reg == HBAH_WAIT && rd_reg && rdata_ok) ? reg_rdata : rdata_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= HBAH_IDLE;
      flt_reg   <= 2'b00;
      rdata_reg <= ZERO_BYTE;
      rd_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      flt_reg   <= flt_next;
      rdata_reg <= rdata_next;
      rd_reg    <= rd_next;
    end
  end

  hbah_access_timer u_timer (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .start   (tmr_start),
    .length  (acc_len),
    .expired (tmr_expired),
    .elapsed (tmr_elapsed)
  );

  // ****************************************
  // pin drive
  // ****************************************
  // separate strobe: low while busy, high at completion; direction: high while busy, low at completion
  wire busy = (state_reg == HBAH_WAIT);
  wire done = (state_reg == HBAH_DONE);

  assign ack_drv.oe = dir_mode ? ((active & (busy | done | tmr_start)) | (state_reg == HBAH_HOLD))
                               : (active & (busy | done | tmr_start));
  assign ack_drv.o  = dir_mode ? ~(done & active)
                               : done;
  assign ack_o      = ack_drv.o;
  assign ack_oe     = ack_drv.oe;

  assign data_o  = rdata_reg;
  assign data_oe = drive_ok & rd_active & (busy | done);

  // ****************************************
  // register side
  // ****************************************
  assign req.write = is_write;
  assign req.addr  = addr;
  assign req.wdata = data_i;

  // write strobe at completion so address and data are settled
  assign reg_wr    = busy & tmr_expired & active & req.write;
  assign reg_rd    = busy & rd_reg & active;
  assign reg_addr  = req.addr;
  assign reg_wdata = req.wdata;

endmodule

`default_nettype wire

// File: hbah_pkg.sv
package hbah_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 100;
  localparam int PCLK_PERIOD_NS  = 100;
  // data drive no earlier than 3 x pclkp - 4 ns (least time, round up)
  localparam int DRIVE_MIN_NS    = 3 * PCLK_PERIOD_NS - 4;
  localparam int DRIVE_CYC       = (DRIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // data valid pclkp - 4 ns before completion (least time, round up)
  localparam int SETUP_MIN_NS    = PCLK_PERIOD_NS - 4;
  localparam int SETUP_CYC       = (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ack float 1..5 ns after rising edge in strobe/direction mode
  localparam int FLOAT_MIN_NS    = 1;
  localparam int FLOAT_CYC       = (FLOAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] ACC_FAST_CYC  = 8'h02;
  localparam logic [7:0] ACC_SLOW_CYC  = 8'h06;
  localparam logic [7:0] ACC_SLOW_BASE = 8'h80;
  localparam logic [7:0] DRIVE_CNT     = 8'(DRIVE_CYC);
  localparam logic [7:0] SETUP_CNT     = 8'(SETUP_CYC);
  localparam logic [1:0] FLOAT_CNT     = 2'(FLOAT_CYC);
  localparam logic [7:0] ZERO_BYTE     = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    HBAH_IDLE  = 3'b000,
    HBAH_WAIT  = 3'b001,
    HBAH_DONE  = 3'b010,
    HBAH_HOLD  = 3'b011,
    HBAH_FLOAT = 3'b100
  } hbah_state_type;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hbah_req_type;

  typedef struct packed {
    logic       o;
    logic       oe;
  } hbah_drive_type;

endpackage

// File: hbah_access_timer.sv
`timescale 1ns/100ps
`default_nettype none

module hbah_access_timer
  import hbah_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // control
  input  wire logic       start,
  input  wire logic [7:0] length,
  // status
  output logic            expired,
  output logic [7:0]      elapsed
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       run_reg;
  logic       run_next;

  assign run_next = start | (run_reg & (cnt_reg < length));
  assign cnt_next = start ? ZERO_BYTE : (run_reg & (cnt_reg != 8'hff)) ? cnt_reg + 8'h01 : cnt_reg;
  assign expired  = ~start & run_reg & (cnt_reg >= length);
  assign elapsed  = cnt_reg;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= ZERO_BYTE;
      run_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

endmodule

`default_nettype wire

// File: hbah_sva.sv
`timescale 1ns/100ps
`default_nettype none
module hbah_sva
  import hbah_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // host pins
  input wire logic       dir_mode,
  input wire logic       sel_n,
  input wire logic       write_or_data_strobe_n,
  input wire logic       read_or_dir_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] data_o,
  input wire logic       data_oe,
  input wire logic       ack_o,
  input wire logic       ack_oe
);
  // ****************************************
  // access decode and read age
  // ****************************************
  wire sep = !dir_mode && !sel_n && (!write_or_data_strobe_n || !read_or_dir_n);
  wire dir = dir_mode && !sel_n && !write_or_data_strobe_n;
  wire rda = !sel_n && (dir_mode ? !write_or_data_strobe_n && read_or_dir_n : !read_or_dir_n);
  logic [7:0] cnt_reg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) cnt_reg <= 8'h00;
    else cnt_reg <= rda ? cnt_reg + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  AST_SEP_ACK: assert property (sep |-> ack_oe) else $error("ready not driven");
  AST_SEP_FLOAT: assert property (!dir_mode && !sep |-> !ack_oe) else $error("ready not floated");
  AST_DRIVE_LATE: assert property (data_oe |-> cnt_reg >= 8'h03) else $error("data driven early");
  AST_DATA_FREE: assert property (!rda |-> !data_oe) else $error("data not released");
  AST_SEP_SETUP: assert property (!dir_mode && rda && $rose(ack_o) |-> $past(data_oe) && $stable(data_o))
    else $error("read data late");
  AST_DIR_START: assert property (dir && !$past(dir) |-> ack_oe && ack_o) else $error("ack not high");
  AST_DIR_END: assert property (dir_mode && $fell(dir) |-> ##[0:2] (ack_oe && ack_o) ##[1:2] !ack_oe)
    else $error("ack end wrong");
  AST_FAST_TIME: assert property (!dir_mode && $rose(sep) && !addr[7] |-> ##1 !ack_o [*5] ##1 ack_o)
    else $error("fast time wrong");
  AST_SLOW_TIME: assert property (dir_mode && $rose(dir) && addr[7] |-> ##1 ack_o [*7] ##1 !ack_o)
    else $error("slow time wrong");
endmodule
bind hbah_host_port hbah_sva u_sva (.*);
`default_nettype wire

// File: hbah_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module hbah_host_model (
  // clock
  input  wire logic       clk_sys,
  // host pins
  output logic            dir_mode,
  output logic            sel_n,
  output logic            write_or_data_strobe_n,
  output logic            read_or_dir_n,
  output logic [7:0]      addr,
  output logic [7:0]      data_i,
  input  wire logic [7:0] data_o,
  input  wire logic       ack_o,
  input  wire logic       ack_oe
);
  // ****************************************
  // one host access, early 99 means none
  // ****************************************
  initial begin
    {dir_mode, sel_n, write_or_data_strobe_n, read_or_dir_n} = 4'h7;
    addr = 8'h00;
    data_i = 8'h00;
  end
  task automatic xfer(input logic dm, input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input int early, output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    ok = 0;
    @(posedge clk_sys) #1;
    dir_mode = dm;
    addr = a;
    data_i = wr ? d : ~d;
    if (dm) read_or_dir_n = ~wr;
    @(posedge clk_sys) #1;
    sel_n = 0;
    if (dm || wr) write_or_data_strobe_n = 0;
    else read_or_dir_n = 0;
    while (!ok && n < 20 && n != early) begin
      @(posedge clk_sys);
      n++;
      ok = ack_oe === 1'b1 && ack_o === !dm;
    end
    q = data_o;
    #1 sel_n = 1;
    write_or_data_strobe_n = 1;
    if (!dm) read_or_dir_n = 1;
    addr = ~a;
    data_i = ~data_i;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys, resetn, dir_mode, sel_n, write_or_data_strobe_n, read_or_dir_n;
  logic data_oe, ack_o, ack_oe, reg_wr, reg_rd;
  logic [7:0] addr, data_i, data_o, reg_addr, reg_wdata, wa, wd;
  wire logic [7:0] reg_rdata = ~reg_addr;
  int miscompares = 0;
  int total_checks = 0;
  int wr_seen = 0;
  int rd_seen = 0;
  hbah_host_port DUT (.*);
  hbah_host_model host (.*);
  // ****************************************
  // clock, write capture, helpers
  // ****************************************
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (reg_wr === 1'b1) begin
      wr_seen++;
      wa = reg_addr;
      wd = reg_wdata;
    end
    if (reg_rd === 1'b1) rd_seen++;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task run(input logic dm, input logic wr, input logic [7:0] a, input logic [7:0] d,
           input int early, output logic [7:0] q);
    logic ok;
    host.xfer(dm, wr, a, d, early, q, ok);
    if (ok !== 1'b1 && early == 99) begin
      miscompares++;
      give_verdict();
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_rw(input logic dm);
    logic [7:0] q, a;
    int w;
    int r;
    for (int i = 0; i < 2; i++) begin
      a = i ? 8'h9c : 8'h12;
      w = wr_seen;
      run(dm, 1'b1, a, a + 8'h11, 99, q);
      check(8'(wr_seen - w), 8'h01, "write pulses");
      check(wa, a, "write addr");
      check(wd, a + 8'h11, "write data");
      r = rd_seen;
      run(dm, 1'b0, a, 8'h00, 99, q);
      check(q, ~a, "read data");
      check(8'(rd_seen - r), i ? 8'h07 : 8'h05, "read cycles");
      check(8'(data_oe), 8'h00, "data released");
      check(8'(ack_oe), 8'h00, "ack floated");
    end
  endtask
  task t_abort;
    logic [7:0] q;
    int w;
    w = wr_seen;
    run(1'b0, 1'b1, 8'h85, 8'h3c, 2, q);
    check(8'(wr_seen - w), 8'h00, "aborted write");
    run(1'b0, 1'b0, 8'h44, 8'h00, 99, q);
    check(q, 8'hbb, "read after abort");
  endtask
  initial begin
    resetn = 0;
    repeat (5) @(posedge clk_sys);
    #1 resetn = 1;
    t_rw(1'b0);
    t_rw(1'b1);
    t_abort();
    give_verdict();
  end
endmodule
`default_nettype wire
